// ---- hpp_pkg.sv ----
// package for the handshake parallel port: register map, fields, encodings, pin carriers
package hpp_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] PORT0_ADDR = 8'h00;
    localparam logic [7:0] PORT1_ADDR = 8'h04;
    localparam logic [7:0] PORT2_ADDR = 8'h08;
    localparam logic [7:0] CONFIG_ADDR = 8'h0c;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_MSB = 7;

    // ****************************************
    // parallel_port_config fields
    // ****************************************
    localparam int WIDTH_LSB = 0;
    localparam int WIDTH_MSB = 1;
    localparam int OUT_AVAIL_BIT = 2;
    localparam int LATCH_VACANT_BIT = 3;
    localparam int OUT_AVAIL_INV_BIT = 4;
    localparam int LATCH_VACANT_INV_BIT = 5;
    localparam logic [7:0] CONFIG_WR_MASK = 8'h33;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // ****************************************
    // width field encoding
    // ****************************************
    typedef enum logic [1:0] {
        WIDTH_OFF = 2'b00,
        WIDTH_8 = 2'b01,
        WIDTH_16 = 2'b10,
        WIDTH_24 = 2'b11
    } hpp_width_e;

    // ****************************************
    // data, lanes and pins
    // ****************************************
    localparam int DATA_W = 24;
    localparam int LANES = 3;
    localparam logic [DATA_W-1:0] DATA_RESET = 24'h000000;
    localparam logic [LANES-1:0] LANES_OFF = 3'h0;
    localparam logic [LANES-1:0] LANES_8 = 3'h1;
    localparam logic [LANES-1:0] LANES_16 = 3'h3;
    localparam logic [LANES-1:0] LANES_24 = 3'h7;

    // control inputs from the external party, all active low
    typedef struct packed {
        logic chipSelN;
        logic outEnN;
        logic writeLatchPulseN;
    } hpp_ctrl_s;

    localparam hpp_ctrl_s CTRL_IDLE = 3'h7;

    // handshake outputs toward the external party
    typedef struct packed {
        logic latchVacantOut;
        logic outputAvailOut;
        logic latchVacantOe;
        logic outputAvailOe;
    } hpp_flag_s;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

endpackage : hpp_pkg

// ---- hpp_handshake_parallel_port.sv ----
// handshake parallel port with AHB-Lite register access
//
// Overview of operation
// - transfers are 8, 16 or 24 bits, chosen by config bits 1:0.
// - enabling the port forces control outputs push-pull and control inputs plain.
// - latch vacant pin tells the external party more input data is accepted.
// - output available pin tells the external party output data is waiting.
// - write latch pulse input latches incoming parallel data.
// - output enable input puts the latched output data on the data pins.
// - chip select gates both write latch pulse and output enable.
// - status bit 2 read-only; set by port 0 write, cleared by output enable low.
// - status bit 3 read-only; set by port 0 read, cleared by write pulse low.
// - bit 4 zero: status active low, pin high; one: status high, pin low.
// - bit 5 same polarity scheme for the latch vacant status and pin.
// - data stays on pins while output enable and chip select are both low.
// - output enable rising after a read raises the shared port interrupt.
// - write pulse with chip select captures data, marks full, drops vacant.
// - write pulse rising after a write raises the shared port interrupt.
// - output available status always reads the inverse of its pin.
// - latch vacant status always reads the inverse of its pin.
`timescale 1ns/1ps
`default_nettype none

module hpp_handshake_parallel_port #(
    parameter logic [1:0] CODE_OFF = hpp_pkg::WIDTH_OFF,
    parameter logic [1:0] CODE_8 = hpp_pkg::WIDTH_8,
    parameter logic [1:0] CODE_16 = hpp_pkg::WIDTH_16,
    parameter logic [1:0] CODE_24 = hpp_pkg::WIDTH_24
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // external party pins
    input wire hpp_pkg::hpp_ctrl_s ctrlPins,
    input wire logic [hpp_pkg::DATA_W-1:0] dataIn,
    output logic [hpp_pkg::DATA_W-1:0] dataOut,
    output logic [hpp_pkg::DATA_W-1:0] dataOe,
    output hpp_pkg::hpp_flag_s flagPins,
    // port enabled, so pin configuration is overridden
    output logic portEnabled,
    // shared port interrupt event, one cycle
    output logic sharedIrqPulse
);

    // ****************************************
    // synchronisers
    // ****************************************
    hpp_pkg::hpp_ctrl_s ctrlMeta_q;
    hpp_pkg::hpp_ctrl_s ctrlSync_q;
    hpp_pkg::hpp_ctrl_s ctrlPrev_q;
    logic [hpp_pkg::DATA_W-1:0] dataMeta_q;
    logic [hpp_pkg::DATA_W-1:0] dataSync_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrlMeta_q <= hpp_pkg::CTRL_IDLE;
            ctrlSync_q <= hpp_pkg::CTRL_IDLE;
            ctrlPrev_q <= hpp_pkg::CTRL_IDLE;
        end else begin
            ctrlMeta_q <= ctrlPins;
            ctrlSync_q <= ctrlMeta_q;
            ctrlPrev_q <= ctrlSync_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dataMeta_q <= hpp_pkg::DATA_RESET;
            dataSync_q <= hpp_pkg::DATA_RESET;
        end else begin
            dataMeta_q <= dataIn;
            dataSync_q <= dataMeta_q;
        end
    end

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] config_q;
    logic [hpp_pkg::DATA_W-1:0] outLatch_q;
    logic [hpp_pkg::DATA_W-1:0] inLatch_q;
    logic outAvail_q;
    logic latchVacant_q;
    logic [hpp_pkg::LANES-1:0] lanes;
    logic enabled;

    // ****************************************
    // width decode
    // ****************************************
    always_comb begin
        lanes = hpp_pkg::LANES_OFF;
        if (config_q[hpp_pkg::WIDTH_MSB:hpp_pkg::WIDTH_LSB] == CODE_8) begin
            lanes = hpp_pkg::LANES_8;
        end else if (config_q[hpp_pkg::WIDTH_MSB:hpp_pkg::WIDTH_LSB] == CODE_16) begin
            lanes = hpp_pkg::LANES_16;
        end else if (config_q[hpp_pkg::WIDTH_MSB:hpp_pkg::WIDTH_LSB] == CODE_24) begin
            lanes = hpp_pkg::LANES_24;
        end else if (config_q[hpp_pkg::WIDTH_MSB:hpp_pkg::WIDTH_LSB] == CODE_OFF) begin
            lanes = hpp_pkg::LANES_OFF;
        end
    end

    assign enabled = (lanes != hpp_pkg::LANES_OFF);

    // ****************************************
    // AHB-Lite address and data phase
    // ****************************************
    logic addrPhase;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic rdPort0;
    logic wrPort0;
    logic [31:0] rdData;

    assign addrPhase = hsel && hready && (htrans == hpp_pkg::HTRANS_NONSEQ);
    assign rdPort0 = addrPhase && !hwrite && (haddr[7:0] == hpp_pkg::PORT0_ADDR);
    assign wrPort0 = wrPend_q && (wrAddr_q == hpp_pkg::PORT0_ADDR);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else begin
            wrPend_q <= addrPhase && hwrite;
            wrAddr_q <= haddr[hpp_pkg::ADDR_MSB:hpp_pkg::ADDR_LSB];
        end
    end

    // read mux: status bits read the inverse of their pins
    always_comb begin
        rdData = 32'h00000000;
        unique case (haddr[hpp_pkg::ADDR_MSB:hpp_pkg::ADDR_LSB])
            hpp_pkg::PORT0_ADDR: rdData[7:0] = inLatch_q[7:0];
            hpp_pkg::PORT1_ADDR: rdData[7:0] = inLatch_q[15:8];
            hpp_pkg::PORT2_ADDR: rdData[7:0] = inLatch_q[23:16];
            hpp_pkg::CONFIG_ADDR: begin
                rdData[7:0] = config_q & hpp_pkg::CONFIG_WR_MASK;
                rdData[hpp_pkg::OUT_AVAIL_BIT] = !flagPins.outputAvailOut;
                rdData[hpp_pkg::LATCH_VACANT_BIT] = !flagPins.latchVacantOut;
            end
            default: rdData = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= hpp_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= hpp_pkg::HRESP_OKAY;
            if (addrPhase && !hwrite) begin
                hrdata <= rdData;
            end
        end
    end

    // ****************************************
    // configuration and output latches
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            config_q <= hpp_pkg::CONFIG_RESET;
        end else if (wrPend_q && wrAddr_q == hpp_pkg::CONFIG_ADDR) begin
            config_q <= hwdata[7:0] & hpp_pkg::CONFIG_WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            outLatch_q <= hpp_pkg::DATA_RESET;
        end else if (wrPend_q) begin
            if (wrAddr_q == hpp_pkg::PORT0_ADDR) begin
                outLatch_q[7:0] <= hwdata[7:0];
            end
            if (wrAddr_q == hpp_pkg::PORT1_ADDR) begin
                outLatch_q[15:8] <= hwdata[7:0];
            end
            if (wrAddr_q == hpp_pkg::PORT2_ADDR) begin
                outLatch_q[23:16] <= hwdata[7:0];
            end
        end
    end

    // ****************************************
    // external handshake
    // ****************************************
    logic readActive;
    logic writeActive;
    logic readDone;
    logic writeDone;

    assign readActive = enabled && !ctrlSync_q.chipSelN && !ctrlSync_q.outEnN;
    assign writeActive = enabled && !ctrlSync_q.chipSelN
        && !ctrlSync_q.writeLatchPulseN;
    // rising edge of an access that was gated by chip select
    assign readDone = enabled && !ctrlPrev_q.outEnN && ctrlSync_q.outEnN
        && !ctrlPrev_q.chipSelN;
    assign writeDone = enabled && !ctrlPrev_q.writeLatchPulseN
        && ctrlSync_q.writeLatchPulseN && !ctrlPrev_q.chipSelN;

    // input latch captured while the write pulse is low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            inLatch_q <= hpp_pkg::DATA_RESET;
        end else if (writeActive) begin
            inLatch_q <= dataSync_q;
        end
    end

    // firmware port 0 write wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            outAvail_q <= 1'b0;
        end else if (wrPort0) begin
            outAvail_q <= 1'b1;
        end else if (readActive) begin
            outAvail_q <= 1'b0;
        end
    end

    // firmware port 0 read wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            latchVacant_q <= 1'b1;
        end else if (rdPort0) begin
            latchVacant_q <= 1'b1;
        end else if (writeActive) begin
            latchVacant_q <= 1'b0;
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flagPins <= '0;
            portEnabled <= 1'b0;
        end else begin
            flagPins.outputAvailOut <= outAvail_q
                ^ config_q[hpp_pkg::OUT_AVAIL_INV_BIT];
            flagPins.latchVacantOut <= latchVacant_q
                ^ config_q[hpp_pkg::LATCH_VACANT_INV_BIT];
            flagPins.outputAvailOe <= enabled;
            flagPins.latchVacantOe <= enabled;
            portEnabled <= enabled;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dataOut <= hpp_pkg::DATA_RESET;
            dataOe <= hpp_pkg::DATA_RESET;
        end else begin
            dataOut <= outLatch_q;
            for (int i = 0; i < hpp_pkg::LANES; i++) begin
                dataOe[i*8 +: 8] <= {8{readActive && lanes[i]}};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sharedIrqPulse <= 1'b0;
        end else begin
            sharedIrqPulse <= readDone || writeDone;
        end
    end

endmodule : hpp_handshake_parallel_port

`default_nettype wire

// ---- hpp_props.sv ----
// checker for the handshake parallel port
`timescale 1ns/1ps
`default_nettype none
module hpp_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pins and status
    input wire hpp_pkg::hpp_ctrl_s ctrlPins,
    input wire logic [hpp_pkg::DATA_W-1:0] dataOe,
    input wire hpp_pkg::hpp_flag_s flagPins,
    input wire logic portEnabled,
    input wire logic sharedIrqPulse
);
    logic rdReq;
    logic actReq;
    assign rdReq = !ctrlPins.chipSelN && !ctrlPins.outEnN;
    assign actReq = !ctrlPins.chipSelN && (!ctrlPins.outEnN || !ctrlPins.writeLatchPulseN);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence rdHeld; rdReq [*8]; endsequence
    sequence wrHeld; (!ctrlPins.chipSelN && !ctrlPins.writeLatchPulseN) [*8]; endsequence
    sequence csOff; ctrlPins.chipSelN [*6]; endsequence
    AST_LANES: assert property (dataOe != 24'h0 |->
        dataOe inside {24'h0000ff, 24'h00ffff, 24'hffffff}) else $error("lanes off width");
    AST_FLAG_DRIVE: assert property (flagPins.latchVacantOe == portEnabled
        && flagPins.outputAvailOe == portEnabled) else $error("flag drive wrong");
    AST_OE_ENABLED: assert property (dataOe != 24'h0 |-> portEnabled)
        else $error("data driven while disabled");
    AST_CS_GATE: assert property (csOff |-> dataOe == 24'h0 && !sharedIrqPulse)
        else $error("activity without chip select");
    AST_OE_CAUSE: assert property (dataOe != 24'h0 |->
        $past(rdReq, 2) || $past(rdReq, 3) || $past(rdReq, 4)) else $error("data driven unasked");
    AST_IRQ_ONE: assert property (sharedIrqPulse |=> !sharedIrqPulse)
        else $error("interrupt pulse too long");
    AST_IRQ_CAUSE: assert property (sharedIrqPulse |->
        $past(actReq, 3) || $past(actReq, 4) || $past(actReq, 5)) else $error("stray interrupt");
    AST_AVAIL_HOLD: assert property (rdHeld |-> $stable(flagPins.outputAvailOut))
        else $error("output flag moved during read");
    AST_VACANT_HOLD: assert property (wrHeld |-> $stable(flagPins.latchVacantOut))
        else $error("vacant flag moved during write");
endmodule : hpp_props
bind hpp_handshake_parallel_port hpp_props u_hpp_props (.clk(clk), .reset_n(reset_n),
    .ctrlPins(ctrlPins), .dataOe(dataOe), .flagPins(flagPins), .portEnabled(portEnabled),
    .sharedIrqPulse(sharedIrqPulse));
`default_nettype wire

// ---- hpp_ext_host.sv ----
// model of the external controller driving the port pins
`timescale 1ns/1ps
`default_nettype none
module hpp_ext_host (
    // clock
    input wire logic clk,
    // device side
    input wire logic [hpp_pkg::DATA_W-1:0] dataOut,
    input wire logic [hpp_pkg::DATA_W-1:0] dataOe,
    // control and data pins
    output hpp_pkg::hpp_ctrl_s ctrlPins,
    output logic [hpp_pkg::DATA_W-1:0] dataIn
);
    initial begin
        ctrlPins = hpp_pkg::CTRL_IDLE;
        dataIn = 24'h0;
    end
    // one access; released data lines show the inverse of their last value
    task automatic pulse(input logic [2:0] c, input int hold, input logic [23:0] wd,
        output logic [23:0] d, output logic [23:0] oe);
        @(posedge clk);
        ctrlPins <= c;
        dataIn <= c[0] ? ~dataIn : wd;
        repeat (hold) @(posedge clk);
        d = dataOut;
        oe = dataOe;
        ctrlPins <= hpp_pkg::CTRL_IDLE;
        @(posedge clk);
        dataIn <= ~dataIn;
        repeat (hold) @(posedge clk);
    endtask : pulse
endmodule : hpp_ext_host
`default_nettype wire

// ---- testbench.sv ----
// testbench for the handshake parallel port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    hpp_pkg::hpp_ctrl_s ctrlPins;
    logic [23:0] dataIn;
    logic [23:0] dataOut;
    logic [23:0] dataOe;
    hpp_pkg::hpp_flag_s flagPins;
    logic portEnabled;
    logic sharedIrqPulse;
    int num_errors = 0;
    int total_checks = 0;
    int irqCount = 0;
    int n;
    logic [31:0] rd;
    logic [23:0] seen;
    logic [23:0] oe;
    logic [23:0] mask;
    always #4 clk = ~clk;
    always @(posedge clk) if (sharedIrqPulse === 1'b1) irqCount <= irqCount + 1;
    hpp_handshake_parallel_port u_hpp_handshake_parallel_port (.clk(clk), .reset_n(reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ctrlPins(ctrlPins), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .flagPins(flagPins), .portEnabled(portEnabled),
        .sharedIrqPulse(sharedIrqPulse));
    hpp_ext_host extHost (.clk(clk), .dataOut(dataOut), .dataOe(dataOe),
        .ctrlPins(ctrlPins), .dataIn(dataIn));
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= hpp_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out;
    end
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, hpp_pkg::CONFIG_ADDR, 32'h0, rd);
        check(rd, 32'h04);
        bus(1'b1, 8'h10, 32'hff, rd);
        bus(1'b0, 8'h10, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b1, hpp_pkg::CONFIG_ADDR, 32'hff, rd);
        check({hreadyout, hresp}, 2'b10);
        // pins follow the new polarity one edge after the config write lands
        @(posedge clk);
        bus(1'b0, hpp_pkg::CONFIG_ADDR, 32'h0, rd);
        check(rd, 32'h3b);
        repeat (2) @(posedge clk);
        check({flagPins.latchVacantOut, flagPins.outputAvailOut}, 2'b01);
        $display("test config done");
        for (int w = 1; w < 4; w++) begin
            mask = 24'hffffff >> (8 * (3 - w));
            bus(1'b1, hpp_pkg::CONFIG_ADDR, 32'(w), rd);
            bus(1'b1, hpp_pkg::PORT2_ADDR, 32'ha5, rd);
            bus(1'b1, hpp_pkg::PORT1_ADDR, 32'hc3, rd);
            repeat (2) @(posedge clk);
            check(flagPins.outputAvailOut, 1'b0);
            bus(1'b1, hpp_pkg::PORT0_ADDR, 32'he1, rd);
            repeat (2) @(posedge clk);
            check(flagPins.outputAvailOut, 1'b1);
            check({portEnabled, flagPins.latchVacantOe, flagPins.outputAvailOe}, 3'h7);
            n = irqCount;
            extHost.pulse(3'h1, 4 + 2 * w, 24'h0, seen, oe);
            check(oe, mask);
            check(seen & mask, 24'ha5c3e1 & mask);
            check(irqCount - n, 1);
            bus(1'b0, hpp_pkg::CONFIG_ADDR, 32'h0, rd);
            check({flagPins.outputAvailOut, rd[2]}, 2'b01);
            extHost.pulse(3'h2, 10 - 2 * w, 24'h5a3c96, seen, oe);
            check(irqCount - n, 2);
            bus(1'b0, hpp_pkg::CONFIG_ADDR, 32'h0, rd);
            check({flagPins.latchVacantOut, rd[3]}, 2'b01);
            for (int i = w - 1; i >= 0; i--) begin
                bus(1'b0, 8'(4 * i), 32'h0, rd);
                check(rd, {24'h0, 8'(24'h5a3c96 >> (8 * i))});
            end
            repeat (2) @(posedge clk);
            check(flagPins.latchVacantOut, 1'b1);
            $display("test width %0d done", w);
        end
        n = irqCount;
        extHost.pulse(3'h5, 8, 24'h0, seen, oe);
        check(oe, 24'h0);
        extHost.pulse(3'h6, 8, 24'h123456, seen, oe);
        check({flagPins.latchVacantOut, 32'(irqCount - n)}, 33'h100000000);
        bus(1'b1, hpp_pkg::CONFIG_ADDR, 32'h0, rd);
        repeat (2) @(posedge clk);
        check({portEnabled, flagPins.latchVacantOe, flagPins.outputAvailOe}, 3'h0);
        extHost.pulse(3'h1, 8, 24'h0, seen, oe);
        check(oe, 24'h0);
        $display("test gating done");
        close_out;
    end
endmodule : testbench
`default_nettype wire
